// >>> design/tsr_slave_rx.sv
`timescale 1ns/100ps
module tsr_slave_rx (
    // System clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Bus clock pin, also the link clock
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    // Bus data pin
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Firmware strobes
    input  wire logic       address_write,
    input  wire logic [7:0] address_write_data,
    input  wire logic       buffer_read,
    input  wire logic       irq_clear,
    input  wire logic       clock_release_set,
    // Firmware configuration levels
    input  wire logic       clock_stretch_enable,
    input  wire logic       start_irq_enable,
    input  wire logic       address_hold_enable,
    input  wire logic       data_hold_enable,
    // Status towards firmware
    output logic [7:0]      address_compare_reg,
    output logic [7:0]      receive_buffer,
    output logic            buffer_full_flag,
    output logic            serial_irq_flag,
    output logic            update_address_flag,
    output logic            start_seen,
    output logic            stop_seen,
    output logic            clock_release_bit
);
    logic [2:0]          sync_first;
    logic [2:0]          sync_second;
    logic [2:0]          sync_prev;
    logic                scl_s;
    logic                sda_s;
    logic                sda_prev;
    logic                start_det;
    logic                stop_det;
    logic                byte_event;
    logic                link_rst_n;
    logic [7:0]          link_data;
    tsr_pkg::tsr_phase_e link_phase;
    logic                link_match;
    logic                link_toggle;
    logic                link_sda_oe;
    logic                addr_event;
    logic                data_event;
    logic                address_hold;
    logic                next_address_hold;
    logic                next_clock_release;

    tsr_link_rx u_link (
        .scl_clk             (scl_in),
        .link_rst_n          (link_rst_n),
        .sys_rst_n           (reset_n),
        .sda_in              (sda_in),
        .sda_oe              (link_sda_oe),
        .address_compare_reg (address_compare_reg),
        .byte_data           (link_data),
        .byte_phase          (link_phase),
        .byte_match          (link_match),
        .byte_toggle         (link_toggle)
    );

    assign sda_oe = link_sda_oe;

    // Pins and the event toggle pass two flops; the third stage is only a
    // delayed copy used for edge detection.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_first  <= tsr_pkg::SYNC_RESET;
            sync_second <= tsr_pkg::SYNC_RESET;
            sync_prev   <= tsr_pkg::SYNC_RESET;
        end else begin
            sync_first  <= {scl_in, sda_in, link_toggle};
            sync_second <= sync_first;
            sync_prev   <= sync_second;
        end
    end

    assign scl_s      = sync_second[2];
    assign sda_s      = sync_second[1];
    assign sda_prev   = sync_prev[1];
    assign start_det  = scl_s && sync_prev[2] && sda_prev && !sda_s;
    assign stop_det   = scl_s && sync_prev[2] && !sda_prev && sda_s;
    assign byte_event = sync_second[0] ^ sync_prev[0];
    // Byte value, phase and match cross without synchronisers: the link
    // settles them a full link period before the toggle that announces
    // them and holds them until the eighth bit of the next byte.
    assign addr_event = byte_event &&
                        (link_phase == tsr_pkg::TSR_PH_HIGH ||
                         link_phase == tsr_pkg::TSR_PH_LOW);
    assign data_event = byte_event && (link_phase == tsr_pkg::TSR_PH_DATA);

    // The link is held in reset from a stop until the next start, and is
    // released one cycle after a start while the clock is still high, so
    // that no link edge can meet the release.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link_rst_n <= 1'b0;
        end else if (start_det || stop_det) begin
            link_rst_n <= 1'b0;
        end else if (start_seen) begin
            link_rst_n <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end else if (start_det) begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
        end else if (stop_det) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b1;
        end
    end

    // A new event wins over a firmware clear in the same cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_irq_flag <= 1'b0;
        end else if ((start_det && start_irq_enable) || byte_event) begin
            serial_irq_flag <= 1'b1;
        end else if (irq_clear) begin
            serial_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            update_address_flag <= 1'b0;
        end else if (addr_event) begin
            update_address_flag <= 1'b1;
        end else if (address_write) begin
            update_address_flag <= 1'b0;
        end
    end

    // A mismatching low byte does not fill the buffer.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_buffer   <= tsr_pkg::BYTE_RESET;
            buffer_full_flag <= 1'b0;
        end else if (byte_event && link_match) begin
            receive_buffer   <= link_data;
            buffer_full_flag <= 1'b1;
        end else if (buffer_read) begin
            buffer_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            address_compare_reg <= tsr_pkg::ADDRESS_RESET;
        end else if (address_write) begin
            address_compare_reg <= address_write_data;
        end
    end

    // The clock stays low after every matching high address byte and every low
    // address byte until the compare register is reloaded, so the next byte always meets the new value.
    always_comb begin
        next_address_hold = address_hold;
        if (addr_event) begin
            next_address_hold = 1'b1;
        end else if (address_write) begin
            next_address_hold = 1'b0;
        end
    end

    // A hardware clear wins over a firmware release in the same cycle, as
    // the byte that caused it has not yet been seen by firmware.
    always_comb begin
        next_clock_release = clock_release_bit;
        if (data_event && (clock_stretch_enable || data_hold_enable)) begin
            next_clock_release = 1'b0;
        end else if (addr_event && link_match && address_hold_enable) begin
            next_clock_release = 1'b0;
        end else if (clock_release_set) begin
            next_clock_release = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            address_hold      <= 1'b0;
            clock_release_bit <= tsr_pkg::CLOCK_RELEASE_RESET;
        end else begin
            address_hold      <= next_address_hold;
            clock_release_bit <= next_clock_release;
        end
    end

    // Stretch is taken from the next values so that the pull begins in the
    // low phase after the ninth pulse, before the controller's next rise.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_oe <= 1'b0;
        end else begin
            scl_oe <= next_address_hold || !next_clock_release;
        end
    end

    // Open-drain pins only ever drive low.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

endmodule

// >>> pkg/tsr_pkg.sv
// Summary of operation
// - Start condition sets start flag, optional interrupt.
// - High address match: update flag, acknowledge, interrupt.
// - Buffer read returns address byte, clears full.
// - Firmware loads low address; clock held until then.
// - Low address match: update flag, acknowledge, interrupt.
// - Low mismatch: flags set, buffer empty, release kept.
// - Each data byte acknowledged, then interrupt flag set.
// - Stretch enabled: hardware clears release bit, holds clock.
// - Buffer read returns data byte, clears full.
// - Byte cycle repeats until stop condition.
// - Hold enables behave as seven bit, plus reload.
package tsr_pkg;

    localparam logic [4:0] TEN_BIT_PREFIX      = 5'h1E;
    localparam logic [3:0] BIT_COUNT_RESET     = 4'h0;
    localparam logic [3:0] BIT_COUNT_STEP      = 4'h1;
    localparam logic [3:0] BIT_LAST_DATA       = 4'h7;
    localparam logic [3:0] BIT_ACK             = 4'h8;
    localparam logic [7:0] BYTE_RESET          = 8'h00;
    localparam logic [7:0] ADDRESS_RESET       = 8'h00;
    localparam logic       CLOCK_RELEASE_RESET = 1'b1;
    localparam logic [2:0] SYNC_RESET          = 3'h0;

    typedef enum logic [1:0] {
        TSR_PH_HIGH = 2'b00,
        TSR_PH_LOW  = 2'b01,
        TSR_PH_DATA = 2'b10,
        TSR_PH_IDLE = 2'b11
    } tsr_phase_e;

endpackage

// >>> design/tsr_link_rx.sv
`timescale 1ns/100ps
module tsr_link_rx (
    // Link clock and resets
    input  wire logic                 scl_clk,
    input  wire logic                 link_rst_n,
    input  wire logic                 sys_rst_n,
    // Serial data
    input  wire logic                 sda_in,
    output logic                      sda_oe,
    // Compare value, held stable by firmware while bytes move
    input  wire logic [7:0]           address_compare_reg,
    // Completed byte towards the system clock
    output logic [7:0]                byte_data,
    output tsr_pkg::tsr_phase_e       byte_phase,
    output logic                      byte_match,
    output logic                      byte_toggle
);
    logic [3:0]          bit_count;
    logic [7:0]          shift;
    logic [7:0]          full_byte;
    tsr_pkg::tsr_phase_e phase;
    logic                hi_ok;
    logic                lo_ok;
    logic                ack_now;
    logic                report;

    assign full_byte = {shift[6:0], sda_in};
    assign hi_ok = (full_byte[7:3] == tsr_pkg::TEN_BIT_PREFIX) &&
                   (full_byte[7:1] == address_compare_reg[7:1]) &&
                   !full_byte[0];
    assign lo_ok = (full_byte == address_compare_reg);

    always_ff @(posedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_count <= tsr_pkg::BIT_COUNT_RESET;
            shift     <= tsr_pkg::BYTE_RESET;
        end else if (bit_count == tsr_pkg::BIT_ACK) begin
            bit_count <= tsr_pkg::BIT_COUNT_RESET;
        end else begin
            bit_count <= bit_count + tsr_pkg::BIT_COUNT_STEP;
            shift     <= full_byte;
        end
    end

    // The compare value is read here without a synchroniser because the
    // firmware only changes it while the clock is held low.
    always_ff @(posedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            phase      <= tsr_pkg::TSR_PH_HIGH;
            byte_data  <= tsr_pkg::BYTE_RESET;
            byte_phase <= tsr_pkg::TSR_PH_HIGH;
            byte_match <= 1'b0;
            ack_now    <= 1'b0;
            report     <= 1'b0;
        end else if (bit_count == tsr_pkg::BIT_LAST_DATA) begin
            byte_data  <= full_byte;
            byte_phase <= phase;
            unique case (phase)
                tsr_pkg::TSR_PH_HIGH: begin
                    byte_match <= hi_ok;
                    ack_now    <= hi_ok;
                    report     <= hi_ok;
                    phase      <= hi_ok ? tsr_pkg::TSR_PH_LOW
                                        : tsr_pkg::TSR_PH_IDLE;
                end
                tsr_pkg::TSR_PH_LOW: begin
                    byte_match <= lo_ok;
                    ack_now    <= lo_ok;
                    report     <= 1'b1;
                    phase      <= lo_ok ? tsr_pkg::TSR_PH_DATA
                                        : tsr_pkg::TSR_PH_IDLE;
                end
                tsr_pkg::TSR_PH_DATA: begin
                    byte_match <= 1'b1;
                    ack_now    <= 1'b1;
                    report     <= 1'b1;
                    phase      <= tsr_pkg::TSR_PH_DATA;
                end
                tsr_pkg::TSR_PH_IDLE: begin
                    byte_match <= 1'b0;
                    ack_now    <= 1'b0;
                    report     <= 1'b0;
                    phase      <= tsr_pkg::TSR_PH_IDLE;
                end
            endcase
        end
    end

    // The toggle survives frame resets so that a restart never fakes an event.
    always_ff @(posedge scl_clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            byte_toggle <= 1'b0;
        end else if (link_rst_n && report &&
                     bit_count == tsr_pkg::BIT_ACK) begin
            byte_toggle <= ~byte_toggle;
        end
    end

    // Acknowledge is driven from the fall after the eighth bit to the fall
    // after the ninth.
    always_ff @(negedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= (bit_count == tsr_pkg::BIT_ACK) && ack_now;
        end
    end

endmodule

// >>> bench/tsr_rx_monitor.sv
`timescale 1ns/100ps
module tsr_rx_monitor (
    // System clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Firmware side
    input wire logic       start_irq_enable,
    input wire logic       irq_clear,
    input wire logic       buffer_read,
    input wire logic       address_write,
    input wire logic [7:0] address_write_data,
    // Driven by the design
    input wire logic       scl_oe,
    input wire logic [7:0] address_compare_reg,
    input wire logic       buffer_full_flag,
    input wire logic       serial_irq_flag,
    input wire logic       update_address_flag,
    input wire logic       start_seen,
    input wire logic       stop_seen,
    input wire logic       clock_release_bit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // A stretch comes with its byte event, then the pin is pulled low.
    sequence stall_s;
        ##[0:1] serial_irq_flag ##[0:2] scl_oe;
    endsequence
    start_irq_a: assert property (
        $rose(start_seen) && start_irq_enable |-> ##[0:1] serial_irq_flag)
        else $error("start without irq");
    update_irq_a: assert property (
        $rose(update_address_flag) |-> serial_irq_flag)
        else $error("update flag without irq");
    full_irq_a: assert property (
        $rose(buffer_full_flag) |-> serial_irq_flag)
        else $error("buffer full without irq");
    irq_keep_a: assert property (
        serial_irq_flag && !irq_clear |=> serial_irq_flag)
        else $error("irq flag dropped");
    full_read_a: assert property (
        buffer_read |=> !buffer_full_flag || $rose(serial_irq_flag))
        else $error("read left buffer full");
    addr_load_a: assert property (
        address_write |=> address_compare_reg == $past(address_write_data))
        else $error("compare value not loaded");
    addr_free_a: assert property (
        address_write && clock_release_bit |=> !scl_oe)
        else $error("clock kept low after load");
    stall_a: assert property (
        $fell(clock_release_bit) |-> stall_s)
        else $error("release clear without hold");
    stop_a: assert property (
        $rose(stop_seen) |-> !start_seen)
        else $error("stop left start set");
endmodule
bind tsr_slave_rx tsr_rx_monitor mon (.*);

// >>> bench/tsr_bus_ctl.sv
`timescale 1ns/100ps
module tsr_bus_ctl (
    // Wire levels
    input  wire logic scl,
    input  wire logic sda,
    // Pulls, high drives the wire low
    output logic      scl_low,
    output logic      sda_low
);
    initial {scl_low, sda_low} = 2'b00;
    task automatic start_frame();
        #213 sda_low = 1'b1;
        #160 scl_low = 1'b1;
    endtask
    // The device may hold the clock, so every rise waits it out.
    task automatic clock_bit(input logic b, output logic seen);
        #27 sda_low = ~b;
        #53 scl_low = 1'b0;
        wait (scl === 1'b1);
        seen = sda;
        #80 scl_low = 1'b1;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic nack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], seen);
        end
        clock_bit(1'b1, nack);
    endtask
    task automatic stop_frame();
        #27 sda_low = 1'b1;
        #53 scl_low = 1'b0;
        wait (scl === 1'b1);
        #160 sda_low = 1'b0;
        #200;
    endtask
endmodule

// >>> bench/test_i2c_slave_ten_bit_address_receive.sv
`timescale 1ns/100ps
module test_i2c_slave_ten_bit_address_receive;
    // Row: data byte, stretch enable, data hold enable.
    localparam logic [9:0] ROWS [4] = '{10'h002, 10'h3FC, 10'h171, 10'h28E};
    localparam logic [7:0] HI = 8'hF4;
    localparam logic [7:0] LO = 8'hA5;
    localparam logic [3:0] WR = 4'h8;
    localparam logic [3:0] SVC = 4'h6;
    localparam logic [3:0] CLR = 4'h2;
    localparam logic [3:0] REL = 4'h1;
    logic       clk, reset_n, scl_low, sda_low, nack, hold;
    logic       address_write, buffer_read, irq_clear, clock_release_set;
    logic       clock_stretch_enable, start_irq_enable;
    logic       address_hold_enable, data_hold_enable;
    logic [7:0] address_write_data, address_compare_reg, receive_buffer;
    logic       buffer_full_flag, serial_irq_flag, update_address_flag;
    logic       start_seen, stop_seen, clock_release_bit, scl_oe, sda_oe;
    logic       scl_out, sda_out;
    int         n_mismatch, samples_checked;
    wire logic  scl_line = ~(scl_low | scl_oe);
    wire logic  sda_line = ~(sda_low | sda_oe);
    tsr_slave_rx uut (.*, .scl_in(scl_line), .sda_in(sda_line));
    tsr_bus_ctl ctl (.scl(scl_line), .sda(sda_line), .scl_low(scl_low),
        .sda_low(sda_low));
    task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic check_bit(input logic exp, input logic got);
        check_byte({7'h00, exp}, {7'h00, got});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Strobes last one cycle and drop on the next edge.
    task automatic fw(input logic [3:0] s, input logic [7:0] d);
        @(posedge clk);
        {address_write, buffer_read, irq_clear, clock_release_set} <= s;
        address_write_data <= d;
        @(posedge clk);
        {address_write, buffer_read, irq_clear, clock_release_set} <= 4'h0;
        #1;
    endtask
    task automatic put_byte(input logic [7:0] b);
        ctl.send_byte(b, nack);
        settle(5);
    endtask
    task automatic end_of_test();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {address_write, buffer_read, irq_clear, clock_release_set} = 4'h0;
        {clock_stretch_enable, address_hold_enable, data_hold_enable} = 3'h0;
        start_irq_enable = 1'b1;
        address_write_data = 8'h00;
        n_mismatch = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        settle(1);
        check_bit(1'b1, clock_release_bit);
        check_bit(1'b0, serial_irq_flag | buffer_full_flag | scl_oe);
        check_bit(1'b0, sda_oe | scl_out | sda_out | update_address_flag);
        check_bit(1'b0, start_seen | stop_seen);
        check_byte(8'h00, receive_buffer | address_compare_reg);
        $display("reset test done");
        fw(WR, HI);
        ctl.start_frame();
        settle(4);
        check_bit(1'b1, start_seen & serial_irq_flag);
        fw(CLR, 8'h00);
        put_byte(HI);
        check_bit(1'b0, nack);
        check_bit(1'b1, update_address_flag & serial_irq_flag);
        check_byte(HI, receive_buffer);
        fw(SVC, 8'h00);
        check_bit(1'b0, buffer_full_flag);
        check_bit(1'b1, scl_oe);
        fw(WR, LO);
        check_bit(1'b0, scl_oe);
        put_byte(LO);
        check_bit(1'b0, nack);
        check_bit(1'b1, update_address_flag & serial_irq_flag);
        check_byte(LO, receive_buffer);
        fw(SVC, 8'h00);
        fw(WR, HI);
        foreach (ROWS[i]) begin
            @(posedge clk);
            clock_stretch_enable <= ROWS[i][1];
            data_hold_enable <= ROWS[i][0];
            hold = ROWS[i][1] | ROWS[i][0];
            put_byte(ROWS[i][9:2]);
            check_bit(1'b0, nack);
            check_bit(1'b0, sda_oe);
            check_bit(1'b1, serial_irq_flag & buffer_full_flag);
            check_byte(ROWS[i][9:2], receive_buffer);
            check_bit(~hold, clock_release_bit);
            check_bit(hold, scl_oe);
            fw(SVC, 8'h00);
            check_bit(1'b0, buffer_full_flag);
            fw(REL, 8'h00);
            check_bit(1'b0, scl_oe);
        end
        ctl.stop_frame();
        settle(2);
        check_bit(1'b1, stop_seen & ~start_seen);
        $display("data byte test done");
        @(posedge clk);
        address_hold_enable <= 1'b1;
        ctl.start_frame();
        fw(CLR, 8'h00);
        put_byte(HI);
        check_bit(1'b0, clock_release_bit);
        fw(SVC, 8'h00);
        fw(WR, LO);
        check_bit(1'b1, scl_oe);
        fw(REL, 8'h00);
        check_bit(1'b0, scl_oe);
        put_byte(LO ^ 8'h01);
        check_bit(1'b1, nack);
        check_bit(1'b1, serial_irq_flag & update_address_flag);
        check_bit(1'b0, buffer_full_flag);
        check_bit(1'b1, clock_release_bit);
        fw(WR, HI);
        ctl.stop_frame();
        $display("hold and mismatch test done");
        @(posedge clk);
        address_hold_enable <= 1'b0;
        start_irq_enable <= 1'b0;
        fw(CLR, 8'h00);
        ctl.start_frame();
        settle(4);
        check_bit(1'b1, start_seen & ~serial_irq_flag);
        put_byte(HI ^ 8'h02);
        check_bit(1'b1, nack);
        check_bit(1'b0, serial_irq_flag | scl_oe);
        $display("refused address test done");
        @(posedge clk);
        reset_n <= 1'b0;
        settle(2);
        check_bit(1'b0, start_seen | scl_oe | sda_oe);
        check_byte(8'h00, address_compare_reg);
        @(posedge clk);
        reset_n <= 1'b1;
        settle(3);
        check_bit(1'b1, clock_release_bit);
        ctl.stop_frame();
        settle(2);
        check_bit(1'b1, stop_seen & ~start_seen);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule
